// ===== core/addr_mode_defs.svh
/*
 Timing-free constants of the operand address generator: prebyte codes,
 page-zero limits and reset values.
 Assumes inclusion by bare name from the decoder and sequencer design modules.
*/
`ifndef ADDR_MODE_DEFS_SVH
`define ADDR_MODE_DEFS_SVH
`define PRE_SECOND_INDEX 8'h10
`define PRE_INDIRECT 8'h92
`define PRE_INDIRECT_SECOND 8'h91
`define ZERO_HIGH_BYTE 8'h00
`define ADDR_RESET 16'h0000
`define BYTE_RESET 8'h00
`define MODE_COUNT 5'd17
`define FAMILY_COUNT 3'd7
`endif

// ===== core/addr_mode_pkg.sv
/*
 Types shared by the address generator: mode and family enumerations,
 the decoded-instruction carrier and the memory request carrier.
 Assumes the constants header sits beside it.
*/
package addr_mode_pkg;
    typedef enum logic [4:0] {
        M_INHERENT, M_IMMEDIATE, M_DIR_SHORT, M_DIR_LONG,
        M_IDX_NONE, M_IDX_SHORT, M_IDX_LONG,
        M_IND_SHORT, M_IND_LONG, M_INDIDX_SHORT, M_INDIDX_LONG,
        M_REL_DIR, M_REL_IND, M_BIT_DIR, M_BIT_IND,
        M_BITREL_DIR, M_BITREL_IND
    } mode_t;
    typedef enum logic [2:0] {
        F_INHERENT, F_IMMEDIATE, F_DIRECT, F_INDEXED,
        F_INDIRECT, F_RELATIVE, F_BIT
    } family_t;
    typedef struct packed {
        mode_t mode;
        family_t family;
        logic useSecond;
        logic [1:0] operandBytes;
        logic readPointer;
        logic wordPointer;
        logic isRmw;
        logic illegal;
    } decode_t;
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } mem_req_t;
endpackage

// ===== core/mode_decoder.sv
/*
 Combinational addressing-mode decoder: opcode plus prebyte flags in,
 decoded mode, family, operand byte count and pointer kind out.
 Assumes the opcode is held stable by the sequencer while decoded.
*/
`timescale 1ns/100ps
`include "addr_mode_defs.svh"
module mode_decoder (
    // Instruction
    input wire logic [7:0] opcode,
    input wire logic preSecond,
    input wire logic preIndirect,
    input wire logic preIndSecond,
    // Result
    output addr_mode_pkg::decode_t dec
);
    import addr_mode_pkg::*;
    logic [3:0] hi;
    logic [3:0] lo;
    logic rmwOp;
    assign hi = opcode[7:4];
    assign lo = opcode[3:0];
    // Read-modify-write group by opcode low nibble
    assign rmwOp = (lo == 4'h0) || (lo == 4'h3) || (lo == 4'h4) ||
                   (lo == 4'h6) || (lo == 4'h7) || (lo == 4'h8) ||
                   (lo == 4'h9) || (lo == 4'hA) || (lo == 4'hC) ||
                   (lo == 4'hD) || (lo == 4'hE) || (lo == 4'hF);
    always_comb begin
        dec = '0;
        dec.mode = M_INHERENT;
        dec.family = F_INHERENT;
        dec.useSecond = preSecond | preIndSecond;
        case (hi)
            4'h0: begin
                dec.mode = preIndirect ? M_BITREL_IND : M_BITREL_DIR;
                dec.family = F_BIT;
            end
            4'h1: begin
                dec.mode = preIndirect ? M_BIT_IND : M_BIT_DIR;
                dec.family = F_BIT;
                dec.isRmw = 1'b1;
            end
            4'h2: begin
                dec.mode = preIndirect ? M_REL_IND : M_REL_DIR;
                dec.family = F_RELATIVE;
            end
            4'h3: begin
                dec.mode = preIndirect ? M_IND_SHORT : M_DIR_SHORT;
                dec.family = preIndirect ? F_INDIRECT : F_DIRECT;
                dec.isRmw = rmwOp;
            end
            4'h6: begin
                dec.mode = (preIndirect | preIndSecond) ?
                           M_INDIDX_SHORT : M_IDX_SHORT;
                dec.family = F_INDEXED;
                dec.isRmw = rmwOp;
            end
            4'h7: begin
                dec.mode = M_IDX_NONE;
                dec.family = F_INDEXED;
                dec.isRmw = rmwOp;
            end
            4'hA: begin
                dec.mode = M_IMMEDIATE;
                dec.family = F_IMMEDIATE;
            end
            4'hB: begin
                dec.mode = preIndirect ? M_IND_SHORT : M_DIR_SHORT;
                dec.family = preIndirect ? F_INDIRECT : F_DIRECT;
            end
            4'hC: begin
                dec.mode = preIndirect ? M_IND_LONG : M_DIR_LONG;
                dec.family = preIndirect ? F_INDIRECT : F_DIRECT;
            end
            4'hD: begin
                dec.mode = (preIndirect | preIndSecond) ?
                           M_INDIDX_LONG : M_IDX_LONG;
                dec.family = F_INDEXED;
            end
            4'hE: begin
                dec.mode = (preIndirect | preIndSecond) ?
                           M_INDIDX_SHORT : M_IDX_SHORT;
                dec.family = F_INDEXED;
            end
            4'hF: begin
                dec.mode = M_IDX_NONE;
                dec.family = F_INDEXED;
            end
            default: begin
                dec.mode = M_INHERENT;
                dec.family = F_INHERENT;
            end
        endcase
        // Bytes that follow the opcode before the operand is reached
        case (dec.mode)
            M_INHERENT, M_IDX_NONE: dec.operandBytes = 2'd0;
            M_DIR_LONG, M_IDX_LONG, M_BITREL_DIR: dec.operandBytes = 2'd2;
            M_BITREL_IND: dec.operandBytes = 2'd2;
            default: dec.operandBytes = 2'd1;
        endcase
        dec.readPointer = (dec.mode == M_IND_SHORT) ||
                          (dec.mode == M_IND_LONG) ||
                          (dec.mode == M_INDIDX_SHORT) ||
                          (dec.mode == M_INDIDX_LONG) ||
                          (dec.mode == M_REL_IND) ||
                          (dec.mode == M_BIT_IND) ||
                          (dec.mode == M_BITREL_IND);
        dec.wordPointer = (dec.mode == M_IND_LONG) ||
                          (dec.mode == M_INDIDX_LONG);
        // Long forms never carry read-modify-write operations
        dec.illegal = rmwOp && (hi == 4'hC || hi == 4'hD) &&
                      (lo != 4'h1) && (lo != 4'h2) && (lo != 4'h5) &&
                      (lo != 4'hB);
        dec.illegal = dec.illegal || (preIndSecond && hi != 4'h6 &&
                      hi != 4'hD && hi != 4'hE);
    end
endmodule // mode_decoder

// ===== core/ea_adder.sv
/*
 Unsigned effective-address adder and relative branch target adder.
 Assumes operands are already zero-extended where page zero applies.
*/
`timescale 1ns/100ps
module ea_adder (
    // Operands
    input wire logic [15:0] base,
    input wire logic [7:0] index,
    input wire logic addIndex,
    input wire logic [15:0] pcNext,
    input wire logic [7:0] relOffset,
    // Results
    output logic [15:0] effAddr,
    output logic [15:0] branchTarget
);
    // Carry into the high byte gives 00..1FE for short indexed
    assign effAddr = base + (addIndex ? {8'h00, index} : 16'h0000);
    // Sign extension keeps targets within PC-128..PC+127
    assign branchTarget = pcNext + {{8{relOffset[7]}}, relOffset};
endmodule // ea_adder

// ===== core/operand_addr_gen.sv
/*
 Operand address sequencer of the 8-bit core. Takes prebytes and opcode,
 fetches address, offset and pointer bytes from memory, and presents the
 16-bit effective address or branch target.
 Assumes memory answers a read with rdValid some cycles after rdReq and
 that index registers stay stable during an instruction.
*/
// Functional notes
// - Seventeen modes in seven families
// - Long forms reach full 64 Kbyte space
// - Short forms limited to page zero
// - Read-modify-write only with short forms
// - Inherent is one byte, nothing fetched
// - Immediate: opcode plus one operand byte
// - Short direct: one address byte
// - Long direct: two address bytes
// - Indexed address is unsigned index plus offset
// - No-offset indexed uses index alone
// - Short indexed: byte offset, up to 1FE
// - Long indexed: word offset plus index
// - Indirect reads pointer before operand
// - Short indirect: byte pointer, page zero
// - Long indirect: word pointer from byte address
// - Indirect indexed adds index to pointer
// - Short indirect indexed spans 00 to 1FE
// - Branch target PC-128 to PC+127, next PC
// - No-offset: second index costs one prebyte
// - Prebyte 10 selects second index
// - Prebyte 92 selects indirect forms
// - Prebyte 91 selects second index, indirect
// - Branch adds signed 8-bit offset
`timescale 1ns/100ps
`include "addr_mode_defs.svh"
module operand_addr_gen (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Sequencer control
    input wire logic start,
    input wire logic [15:0] startPc,
    input wire logic [7:0] indexFirst,
    input wire logic [7:0] indexSecond,
    // Memory read port
    output addr_mode_pkg::mem_req_t rdReq,
    input wire logic rdValid,
    input wire logic [7:0] rdData,
    // Results
    output logic done,
    output logic busy,
    output logic illegal,
    output addr_mode_pkg::mode_t modeOut,
    output addr_mode_pkg::family_t familyOut,
    output logic [15:0] effAddr,
    output logic [7:0] immValue,
    output logic immValid,
    output logic [15:0] branchTarget,
    output logic branchValid,
    output logic [15:0] nextPc
);
    import addr_mode_pkg::*;
    typedef enum logic [2:0] {
        S_IDLE, S_OPCODE, S_OPERAND, S_PTR_HI, S_PTR_LO, S_FINISH
    } state_t;
    state_t state_reg;
    logic [15:0] pc_reg;
    logic [7:0] opcode_reg;
    logic preSecond_reg;
    logic preIndirect_reg;
    logic preIndSecond_reg;
    logic [1:0] left_reg;
    logic [15:0] field_reg;
    logic [15:0] ptrAddr_reg;
    logic reqPending_reg;
    decode_t dec;
    logic [15:0] base;
    logic [7:0] index;
    logic addIndex;
    logic [15:0] sumAddr;
    logic [15:0] target;
    logic [7:0] relOffset;
    logic isPrebyte;

    mode_decoder u_dec (
        .opcode(opcode_reg),
        .preSecond(preSecond_reg),
        .preIndirect(preIndirect_reg),
        .preIndSecond(preIndSecond_reg),
        .dec(dec)
    );

    assign isPrebyte = (rdData == `PRE_SECOND_INDEX) ||
                       (rdData == `PRE_INDIRECT) ||
                       (rdData == `PRE_INDIRECT_SECOND);
    // Second index chosen by prebyte; no-offset Y form costs that byte
    assign index = dec.useSecond ? indexSecond : indexFirst;
    assign addIndex = (dec.family == F_INDEXED);
    // Page-zero forms are zero-extended to 16 bits
    always_comb begin
        base = field_reg;
        case (dec.mode)
            M_IDX_NONE: base = `ADDR_RESET;
            M_DIR_SHORT, M_BIT_DIR, M_BITREL_DIR, M_IDX_SHORT,
            M_IND_SHORT, M_INDIDX_SHORT, M_BIT_IND, M_BITREL_IND:
                base = {`ZERO_HIGH_BYTE, field_reg[7:0]};
            default: base = field_reg;
        endcase
    end
    assign relOffset = field_reg[7:0];

    ea_adder u_add (
        .base(base),
        .index(index),
        .addIndex(addIndex),
        .pcNext(pc_reg),
        .relOffset(relOffset),
        .effAddr(sumAddr),
        .branchTarget(target)
    );

    // Sequencer; one memory read in flight at a time keeps ordering simple
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= S_IDLE;
            pc_reg <= `ADDR_RESET;
            opcode_reg <= `BYTE_RESET;
            preSecond_reg <= 1'b0;
            preIndirect_reg <= 1'b0;
            preIndSecond_reg <= 1'b0;
            left_reg <= 2'd0;
            field_reg <= `ADDR_RESET;
            ptrAddr_reg <= `ADDR_RESET;
            reqPending_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        pc_reg <= startPc;
                        preSecond_reg <= 1'b0;
                        preIndirect_reg <= 1'b0;
                        preIndSecond_reg <= 1'b0;
                        field_reg <= `ADDR_RESET;
                        reqPending_reg <= 1'b0;
                        state_reg <= S_OPCODE;
                    end
                end
                S_OPCODE: begin
                    if (!reqPending_reg) begin
                        reqPending_reg <= 1'b1;
                    end else if (rdValid) begin
                        reqPending_reg <= 1'b0;
                        pc_reg <= pc_reg + 16'h0001;
                        if (isPrebyte) begin
                            preSecond_reg <= (rdData == `PRE_SECOND_INDEX);
                            preIndirect_reg <= (rdData == `PRE_INDIRECT);
                            preIndSecond_reg <= (rdData == `PRE_INDIRECT_SECOND);
                        end else begin
                            opcode_reg <= rdData;
                            state_reg <= S_OPERAND;
                        end
                    end
                end
                S_OPERAND: begin
                    if (left_reg == 2'd0 && !reqPending_reg) begin
                        left_reg <= dec.operandBytes;
                        reqPending_reg <= (dec.operandBytes != 2'd0);
                        if (dec.operandBytes == 2'd0) begin
                            state_reg <= S_FINISH;
                        end
                    end else if (rdValid) begin
                        pc_reg <= pc_reg + 16'h0001;
                        // Bit-relative: first byte is the address, last the offset
                        if (dec.family == F_BIT && left_reg == 2'd1 &&
                            dec.operandBytes == 2'd2) begin
                            ptrAddr_reg <= {`ZERO_HIGH_BYTE, field_reg[7:0]};
                            field_reg <= {field_reg[7:0], rdData};
                        end else begin
                            field_reg <= {field_reg[7:0], rdData};
                        end
                        left_reg <= left_reg - 2'd1;
                        if (left_reg == 2'd1) begin
                            reqPending_reg <= 1'b0;
                            state_reg <= dec.readPointer ? S_PTR_HI : S_FINISH;
                        end
                    end
                end
                S_PTR_HI: begin
                    // Pointer address is the last byte fetched after the opcode
                    if (!reqPending_reg) begin
                        ptrAddr_reg <= {`ZERO_HIGH_BYTE, field_reg[7:0]};
                        reqPending_reg <= 1'b1;
                    end else if (rdValid) begin
                        reqPending_reg <= 1'b0;
                        field_reg <= {8'h00, rdData};
                        ptrAddr_reg <= ptrAddr_reg + 16'h0001;
                        state_reg <= dec.wordPointer ? S_PTR_LO : S_FINISH;
                    end
                end
                S_PTR_LO: begin
                    if (!reqPending_reg) begin
                        reqPending_reg <= 1'b1;
                    end else if (rdValid) begin
                        reqPending_reg <= 1'b0;
                        field_reg <= {field_reg[7:0], rdData};
                        state_reg <= S_FINISH;
                    end
                end
                S_FINISH: begin
                    left_reg <= 2'd0;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Memory request: opcode and operand bytes from PC, pointers elsewhere
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdReq <= '0;
        end else begin
            rdReq.valid <= 1'b0;
            if ((state_reg == S_OPCODE && !reqPending_reg) ||
                (state_reg == S_OPERAND && left_reg == 2'd0 &&
                 !reqPending_reg && dec.operandBytes != 2'd0) ||
                (state_reg == S_OPERAND && rdValid && left_reg > 2'd1)) begin
                rdReq.valid <= 1'b1;
                rdReq.addr <= (state_reg == S_OPERAND && rdValid) ?
                              pc_reg + 16'h0001 : pc_reg;
            end else if (state_reg == S_PTR_HI && !reqPending_reg) begin
                rdReq.valid <= 1'b1;
                rdReq.addr <= {`ZERO_HIGH_BYTE, field_reg[7:0]};
            end else if (state_reg == S_PTR_LO && !reqPending_reg) begin
                rdReq.valid <= 1'b1;
                rdReq.addr <= ptrAddr_reg;
            end
        end
    end

    // Result outputs, registered at the finishing cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            done <= 1'b0;
            illegal <= 1'b0;
            modeOut <= M_INHERENT;
            familyOut <= F_INHERENT;
            effAddr <= `ADDR_RESET;
            immValue <= `BYTE_RESET;
            immValid <= 1'b0;
            branchTarget <= `ADDR_RESET;
            branchValid <= 1'b0;
            nextPc <= `ADDR_RESET;
        end else begin
            done <= (state_reg == S_FINISH);
            if (state_reg == S_FINISH) begin
                illegal <= dec.illegal;
                modeOut <= dec.mode;
                familyOut <= dec.family;
                // Direct bit-relative keeps its address byte apart from the offset
                effAddr <= (dec.mode == M_BITREL_DIR) ? ptrAddr_reg :
                           sumAddr;
                immValue <= field_reg[7:0];
                immValid <= (dec.mode == M_IMMEDIATE);
                branchTarget <= target;
                branchValid <= (dec.family == F_RELATIVE) ||
                               (dec.mode == M_BITREL_DIR) ||
                               (dec.mode == M_BITREL_IND);
                nextPc <= pc_reg;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg != S_IDLE) || start;
        end
    end
endmodule // operand_addr_gen

// ===== tb/mem_model.sv
/*
 Behavioural program and data memory for the operand address generator.
 Assumes one read outstanding; slow adds two wait cycles per answer.
*/
`timescale 1ns/100ps
module mem_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Request and pacing
    input wire addr_mode_pkg::mem_req_t rdReq,
    input wire logic slow,
    // Answer
    output logic rdValid,
    output logic [7:0] rdData
);
    import addr_mode_pkg::*;
    logic [7:0] mem [0:65535];
    logic [15:0] addrReg;
    logic [1:0] waitReg;
    logic pendReg;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pendReg <= 1'b0;
            rdValid <= 1'b0;
            rdData <= 8'h5a;
        end else begin
            rdValid <= 1'b0;
            // Idle data toggles so a stale byte is never mistaken for data
            rdData <= ~rdData;
            if (rdReq.valid) begin
                pendReg <= 1'b1;
                addrReg <= rdReq.addr;
                waitReg <= slow ? 2'h2 : 2'h0;
            end else if (pendReg && waitReg != 2'h0) begin
                waitReg <= waitReg - 2'h1;
            end else if (pendReg) begin
                pendReg <= 1'b0;
                rdValid <= 1'b1;
                rdData <= mem[addrReg];
            end
        end
    end
endmodule // mem_model

// ===== tb/operand_addr_gen_sva.sv
/*
 Port checker of the operand address generator, bound to its top.
 Assumes every read byte is a code or pointer byte of this instruction.
*/
`timescale 1ns/100ps
module operand_addr_gen_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Control
    input wire logic start,
    input wire logic [15:0] startPc,
    // Memory
    input wire addr_mode_pkg::mem_req_t rdReq,
    input wire logic rdValid,
    input wire logic [7:0] rdData,
    // Results
    input wire logic done,
    input wire logic busy,
    input wire addr_mode_pkg::mode_t modeOut,
    input wire logic [15:0] effAddr,
    input wire logic [7:0] immValue,
    input wire logic immValid,
    input wire logic [15:0] branchTarget,
    input wire logic branchValid,
    input wire logic [15:0] nextPc
);
    import addr_mode_pkg::*;
    logic [15:0] pcStart, reqLast;
    logic [7:0] d0, d1, d2;
    logic [3:0] nReads;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Last three bytes read and the byte count since start
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pcStart <= 16'h0000;
            reqLast <= 16'h0000;
            nReads <= 4'h0;
        end else begin
            if (start && !busy) begin
                pcStart <= startPc;
                nReads <= 4'h0;
            end
            if (rdValid) begin
                d0 <= rdData;
                d1 <= d0;
                d2 <= d1;
                nReads <= nReads + 4'h1;
            end
            if (rdReq.valid) begin
                reqLast <= rdReq.addr;
            end
        end
    end
    chk_inherent_len: assert property (
        done && modeOut == M_INHERENT |-> nextPc == pcStart + 16'(nReads))
        else $error("inherent length wrong");
    chk_imm_operand: assert property (
        done && modeOut == M_IMMEDIATE |-> immValid && immValue == d0
        && nextPc == pcStart + 16'(nReads)) else $error("immediate wrong");
    chk_short_dir: assert property (
        done && modeOut == M_DIR_SHORT |-> effAddr == {8'h00, d0})
        else $error("short direct address wrong");
    chk_long_dir: assert property (
        done && modeOut == M_DIR_LONG |-> effAddr == {d1, d0})
        else $error("long direct address wrong");
    chk_short_ind: assert property (
        done && modeOut == M_IND_SHORT |-> effAddr == {8'h00, d0}
        && reqLast == {8'h00, d1}) else $error("short indirect wrong");
    chk_long_ind: assert property (
        done && modeOut == M_IND_LONG |-> effAddr == {d1, d0}
        && reqLast == {8'h00, d2} + 16'h0001)
        else $error("long indirect wrong");
    chk_branch_sum: assert property (
        done && modeOut == M_REL_DIR |-> branchValid
        && branchTarget == nextPc + {{8{d0[7]}}, d0}
        && nextPc == pcStart + 16'(nReads)) else $error("branch wrong");
    // A start right after done is taken at once, so busy may stay up
    chk_done_pulse: assert property (done |=> !done && busy == $past(start))
        else $error("done not a single pulse");
    chk_start_taken: assert property (start && !busy |=> busy [*2])
        else $error("start not taken");
    chk_req_busy: assert property (rdReq.valid |-> busy && !done)
        else $error("read outside an instruction");
endmodule // operand_addr_gen_sva

bind operand_addr_gen operand_addr_gen_sva u_chk (.ref_clk(ref_clk),
    .rst_b(rst_b), .start(start), .startPc(startPc), .rdReq(rdReq),
    .rdValid(rdValid), .rdData(rdData), .done(done), .busy(busy),
    .modeOut(modeOut), .effAddr(effAddr), .immValue(immValue),
    .immValid(immValid), .branchTarget(branchTarget),
    .branchValid(branchValid), .nextPc(nextPc));

// ===== tb/tb_top.sv
/*
 Self-checking bench of the operand address generator with memory model.
 Assumes the design answers every start with done within 100 cycles.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin nFail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    import addr_mode_pkg::*;
    logic ref_clk, rst_b, start, slow, rdValid, done, busy, illegal;
    logic immValid, branchValid;
    logic [15:0] startPc, effAddr, branchTarget, nextPc;
    logic [7:0] indexFirst, indexSecond, rdData, immValue;
    mem_req_t rdReq;
    mode_t modeOut;
    family_t familyOut;
    int nFail, checkCount, cycles;
    operand_addr_gen u_operand_addr_gen (.ref_clk(ref_clk), .rst_b(rst_b),
        .start(start), .startPc(startPc), .indexFirst(indexFirst),
        .indexSecond(indexSecond), .rdReq(rdReq), .rdValid(rdValid),
        .rdData(rdData), .done(done), .busy(busy), .illegal(illegal),
        .modeOut(modeOut), .familyOut(familyOut), .effAddr(effAddr),
        .immValue(immValue), .immValid(immValid),
        .branchTarget(branchTarget), .branchValid(branchValid),
        .nextPc(nextPc));
    mem_model u_mem_model (.ref_clk(ref_clk), .rst_b(rst_b), .rdReq(rdReq),
        .slow(slow), .rdValid(rdValid), .rdData(rdData));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Whole run needs about 360 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            nFail++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (nFail == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic put(input logic [15:0] a, input logic [7:0] b0, b1, b2);
        u_mem_model.mem[a] = b0;
        u_mem_model.mem[16'(a + 16'h0001)] = b1;
        u_mem_model.mem[16'(a + 16'h0002)] = b2;
    endtask
    task automatic exec(input logic [15:0] pc);
        int n;
        n = 0;
        @(posedge ref_clk);
        #1 startPc = pc;
        start = 1'b1;
        @(posedge ref_clk);
        #1 start = 1'b0;
        while (done !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1 n++;
        end
        `CHK(done, 1'b1)
    endtask
    task automatic res(input mode_t m, input logic [15:0] ea, np);
        `CHK(modeOut, m)
        `CHK(effAddr, ea)
        `CHK(nextPc, np)
    endtask
    task automatic t_simple();
        put(16'h0100, 8'h80, 8'ha5, 8'h55);
        exec(16'h0100);
        `CHK(familyOut, F_INHERENT)
        `CHK(nextPc, 16'h0101)
        exec(16'h0101);
        `CHK(immValue, 8'h55)
        `CHK(nextPc, 16'h0103)
        put(16'h0110, 8'h10, 8'ha5, 8'h3c);
        exec(16'h0110);
        `CHK(immValue, 8'h3c)
    endtask
    task automatic t_direct();
        put(16'h0120, 8'hb0, 8'h80, 8'h00);
        exec(16'h0120);
        res(M_DIR_SHORT, 16'h0080, 16'h0122);
        `CHK(illegal, 1'b0)
        put(16'h0130, 8'hc0, 8'h12, 8'h34);
        exec(16'h0130);
        res(M_DIR_LONG, 16'h1234, 16'h0133);
        `CHK(illegal, 1'b1)
    endtask
    task automatic t_indexed();
        put(16'h0140, 8'hf0, 8'h10, 8'hf0);
        exec(16'h0140);
        res(M_IDX_NONE, 16'h00ff, 16'h0141);
        exec(16'h0141);
        res(M_IDX_NONE, 16'h003c, 16'h0143);
        put(16'h0150, 8'he0, 8'hff, 8'h00);
        exec(16'h0150);
        res(M_IDX_SHORT, 16'h01fe, 16'h0152);
        put(16'h0160, 8'hd0, 8'h12, 8'h00);
        exec(16'h0160);
        res(M_IDX_LONG, 16'h12ff, 16'h0163);
    endtask
    task automatic t_indirect();
        put(16'h0040, 8'h77, 8'h00, 8'h00);
        put(16'h0050, 8'hab, 8'hcd, 8'h00);
        put(16'h0170, 8'h92, 8'hb0, 8'h40);
        exec(16'h0170);
        res(M_IND_SHORT, 16'h0077, 16'h0173);
        put(16'h0180, 8'h92, 8'hc0, 8'h50);
        exec(16'h0180);
        res(M_IND_LONG, 16'habcd, 16'h0183);
        put(16'h0190, 8'h92, 8'he0, 8'h40);
        exec(16'h0190);
        res(M_INDIDX_SHORT, 16'h0176, 16'h0193);
        put(16'h01a0, 8'h91, 8'he0, 8'h40);
        exec(16'h01a0);
        res(M_INDIDX_SHORT, 16'h00b3, 16'h01a3);
        put(16'h01b0, 8'h92, 8'hd0, 8'h50);
        exec(16'h01b0);
        res(M_INDIDX_LONG, 16'haccc, 16'h01b3);
        put(16'h01c0, 8'h91, 8'hb0, 8'h40);
        exec(16'h01c0);
        `CHK(illegal, 1'b1)
    endtask
    task automatic t_branch();
        put(16'h0200, 8'h20, 8'h80, 8'h00);
        exec(16'h0200);
        `CHK(branchTarget, 16'h0182)
        put(16'h0210, 8'h20, 8'h7f, 8'h00);
        exec(16'h0210);
        `CHK(branchTarget, 16'h0291)
        put(16'h0060, 8'h80, 8'h00, 8'h00);
        put(16'h0220, 8'h92, 8'h20, 8'h60);
        exec(16'h0220);
        `CHK(modeOut, M_REL_IND)
        `CHK(branchTarget, 16'h01a3)
        put(16'h0300, 8'h11, 8'h40, 8'h00);
        exec(16'h0300);
        res(M_BIT_DIR, 16'h0040, 16'h0302);
        put(16'h0310, 8'h01, 8'h40, 8'h05);
        exec(16'h0310);
        res(M_BITREL_DIR, 16'h0040, 16'h0313);
        `CHK(branchTarget, 16'h0318)
    endtask
    initial begin
        rst_b = 1'b0;
        start = 1'b0;
        slow = 1'b0;
        startPc = 16'h0000;
        indexFirst = 8'hff;
        indexSecond = 8'h3c;
        repeat (3) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        t_simple();
        t_direct();
        // Slow memory must not change any result
        slow = 1'b1;
        t_indexed();
        t_indirect();
        slow = 1'b0;
        t_branch();
        finish_test();
    end
endmodule // tb_top
